// ---- common/ldor_defines.svh ----
`ifndef LDOR_DEFINES_SVH
`define LDOR_DEFINES_SVH

// ----------------------------------------------------------------
// address map: byte address = {bank, index, 2'b00}
// ----------------------------------------------------------------
`define LDOR_ADDR_W       13
`define LDOR_BANK_FLOPPY  3'h0
`define LDOR_BANK_PAR     3'h3
`define LDOR_BANK_SER1    3'h4
`define LDOR_BANK_LOCAL   3'h7
`define LDOR_IDX_PP_MODE  8'hf0
`define LDOR_IDX_SER1     8'hf0
`define LDOR_IDX_PP_MODE2 8'hf1
`define LDOR_IDX_DTYPE    8'hf2
`define LDOR_IDX_FRSVD    8'hf3
`define LDOR_IDX_DRV0     8'hf4
`define LDOR_IDX_DRV1     8'hf5
`define LDOR_IDX_INT_STAT 8'h00
`define LDOR_IDX_INT_MASK 8'h01
`define LDOR_IDX_EPP_FLAG 8'h02

// ----------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------
`define LDOR_PP_MODE_RST  8'h3c
`define LDOR_PP_MODE2_RST 8'h00
`define LDOR_SER1_RST     8'h00
`define LDOR_DTYPE_RST    8'hff
`define LDOR_DRV_RST      8'h00
`define LDOR_DRV_WMASK    8'h5b
`define LDOR_SER1_WMASK   8'h83
`define LDOR_PP2_WMASK    8'h10

// ----------------------------------------------------------------
// field positions and bus answers
// ----------------------------------------------------------------
`define LDOR_PP_PULSE_BIT 7
`define LDOR_PP2_TMO_BIT  4
`define LDOR_SER_SHARE    7
`define LDOR_PRECOMP_BIT  6
`define LDOR_INT_TMO      0
`define LDOR_INT_ACK      1
`define LDOR_RESP_OKAY    2'h0
`define LDOR_RESP_SLVERR  2'h2

`endif

// ---- common/ldor_pkg.sv ----
package ldor_pkg;

  typedef enum logic [2:0] {
    PP_SPP      = 3'b000,
    PP_EPP19    = 3'b001,
    PP_ECP      = 3'b010,
    PP_ECPEPP19 = 3'b011,
    PP_PRINTER  = 3'b100,
    PP_EPP17    = 3'b101,
    PP_RSVD     = 3'b110,
    PP_ECPEPP17 = 3'b111
  } ldor_ppmode_e;

  typedef enum logic [3:0] {
    SEL_NONE     = 4'b0000,
    SEL_PP_MODE  = 4'b0001,
    SEL_PP_MODE2 = 4'b0010,
    SEL_SER1     = 4'b0011,
    SEL_DTYPE    = 4'b0100,
    SEL_FRSVD    = 4'b0101,
    SEL_DRV0     = 4'b0110,
    SEL_DRV1     = 4'b0111,
    SEL_INT_STAT = 4'b1000,
    SEL_INT_MASK = 4'b1001,
    SEL_EPP_FLAG = 4'b1010
  } ldor_sel_e;

  typedef struct packed {
    logic [1:0] driveTypeSelect;
    logic [1:0] rateTableSelect;
    logic       precompDisable;
  } ldor_drvopt_s;

  typedef struct packed {
    ldor_ppmode_e mode;
    logic [3:0]   fifoThreshold;
    logic         pulseIrq;
    logic         timeoutByRead;
  } ldor_paropt_s;

  typedef struct packed {
    logic midiEnable;
    logic highSpeed;
    logic shareIrq;
  } ldor_seropt_s;

  typedef struct packed {
    logic [7:0]  ppMode;
    logic [7:0]  ppMode2;
    logic [7:0]  serMode;
    logic [7:0]  driveType;
    logic [7:0]  drv0;
    logic [7:0]  drv1;
    logic [1:0]  intStat;
    logic [1:0]  intMask;
    logic        eppFlag;
    logic        readDly;
    logic        ackDly;
    logic        awHeld;
    logic        wHeld;
    logic [12:0] awAddr;
    logic [7:0]  wData;
    logic        wStrb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic        irq;
    logic        ppIrqOut;
    logic        ppIrqOe;
    logic        uart1Out;
    logic        uart2Out;
  } ldor_state_s;

endpackage

// ---- rtl/ldor_option_regs.sv ----
// Contract
// - drive type register F2: A in 1:0, B in 3:2, 7:4 spare, resets 0xFF
// - floppy index F3 is read-only and always reads zero
// - drive option F4: type 1:0, rate table 4:3, bits 2,5,7 zero, reset 0x00
// - option bit 6 set disables write precompensation, clear enables it
// - drive option F5 has the same layout and reset as F4
// - parallel mode bits 2:0 decode to printer, SPP, EPP, ECP combinations
// - parallel mode bits 6:3 hold FIFO threshold 0111, register resets 0x3C
// - style bit one pulses interrupt low then releases; zero follows acknowledge
// - style ignored in printer and SPP modes; level interrupt in ECP modes
// - mode-two bit 4 picks timeout clear: write one, or end of read
// - serial mode bit 0 enables MIDI, bit 1 high speed, reset 0x00
// - serial mode bit 7 makes both ports share one interrupt
// - with sharing set, both interrupt lines assert when either port interrupts
`timescale 1ns/1ps
`include "ldor_defines.svh"

module ldor_option_regs (
  input  wire logic                      clock,           // 40 MHz system clock
  input  wire logic                      rst,             // synchronous reset, active high
  input  wire logic [`LDOR_ADDR_W-1:0]   awaddr,          // write address
  input  wire logic                      awvalid,         // write address valid
  output logic                           awready,         // write address ready
  input  wire logic [31:0]               wdata,           // write data
  input  wire logic [3:0]                wstrb,           // write byte strobes
  input  wire logic                      wvalid,          // write data valid
  output logic                           wready,          // write data ready
  output logic [1:0]                     bresp,           // write response
  output logic                           bvalid,          // write response valid
  input  wire logic                      bready,          // write response ready
  input  wire logic [`LDOR_ADDR_W-1:0]   araddr,          // read address
  input  wire logic                      arvalid,         // read address valid
  output logic                           arready,         // read address ready
  output logic [31:0]                    rdata,           // read data
  output logic [1:0]                     rresp,           // read response
  output logic                           rvalid,          // read data valid
  input  wire logic                      rready,          // read data ready
  output logic                           irq,             // level interrupt, high active
  output logic [7:0]                     driveTypeStore,  // stored drive types
  output ldor_pkg::ldor_drvopt_s         drive0Opt,       // first drive options
  output ldor_pkg::ldor_drvopt_s         drive1Opt,       // second drive options
  output ldor_pkg::ldor_paropt_s         parallelOpt,     // parallel port options
  output ldor_pkg::ldor_seropt_s         serialOpt,       // serial port 1 options
  input  wire logic                      ackN,            // parallel acknowledge, low active
  input  wire logic                      ecpIrqReq,       // ecp core level request
  output logic                           ppIrqOut,        // parallel interrupt pin value
  output logic                           ppIrqOe,         // parallel interrupt pin enable
  input  wire logic                      eppTimeoutSet,   // epp timeout event pulse
  input  wire logic                      eppStatusRead,   // high during epp status read
  output logic                           eppTimeoutFlag,  // epp timeout flag
  input  wire logic                      uart1Irq,        // serial port 1 request
  input  wire logic                      uart2Irq,        // serial port 2 request
  output logic                           uart1IrqOut,     // serial port 1 interrupt line
  output logic                           uart2IrqOut      // serial port 2 interrupt line
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // one map for both the read and the write path
  function automatic ldor_pkg::ldor_sel_e decodeAddr(input logic [`LDOR_ADDR_W-1:0] a);
    logic [2:0] bank;
    logic [7:0] idx;
    bank = a[12:10];
    idx  = a[9:2];
    decodeAddr = ldor_pkg::SEL_NONE;
    if (a[1:0] != 2'h0) begin
      decodeAddr = ldor_pkg::SEL_NONE;
    end else if (bank == `LDOR_BANK_FLOPPY && idx == `LDOR_IDX_DTYPE) begin
      decodeAddr = ldor_pkg::SEL_DTYPE;
    end else if (bank == `LDOR_BANK_FLOPPY && idx == `LDOR_IDX_FRSVD) begin
      decodeAddr = ldor_pkg::SEL_FRSVD;
    end else if (bank == `LDOR_BANK_FLOPPY && idx == `LDOR_IDX_DRV0) begin
      decodeAddr = ldor_pkg::SEL_DRV0;
    end else if (bank == `LDOR_BANK_FLOPPY && idx == `LDOR_IDX_DRV1) begin
      decodeAddr = ldor_pkg::SEL_DRV1;
    end else if (bank == `LDOR_BANK_PAR && idx == `LDOR_IDX_PP_MODE) begin
      decodeAddr = ldor_pkg::SEL_PP_MODE;
    end else if (bank == `LDOR_BANK_PAR && idx == `LDOR_IDX_PP_MODE2) begin
      decodeAddr = ldor_pkg::SEL_PP_MODE2;
    end else if (bank == `LDOR_BANK_SER1 && idx == `LDOR_IDX_SER1) begin
      decodeAddr = ldor_pkg::SEL_SER1;
    end else if (bank == `LDOR_BANK_LOCAL && idx == `LDOR_IDX_INT_STAT) begin
      decodeAddr = ldor_pkg::SEL_INT_STAT;
    end else if (bank == `LDOR_BANK_LOCAL && idx == `LDOR_IDX_INT_MASK) begin
      decodeAddr = ldor_pkg::SEL_INT_MASK;
    end else if (bank == `LDOR_BANK_LOCAL && idx == `LDOR_IDX_EPP_FLAG) begin
      decodeAddr = ldor_pkg::SEL_EPP_FLAG;
    end
  endfunction

  // epp transfer modes without the ecp layer
  function automatic logic isEpp(input logic [2:0] m);
    isEpp = (m == ldor_pkg::PP_EPP19) || (m == ldor_pkg::PP_EPP17);
  endfunction

  // any mode that carries the ecp layer
  function automatic logic isEcp(input logic [2:0] m);
    isEcp = (m == ldor_pkg::PP_ECP) || (m == ldor_pkg::PP_ECPEPP19) || (m == ldor_pkg::PP_ECPEPP17);
  endfunction

  ldor_pkg::ldor_state_s st_r;
  ldor_pkg::ldor_state_s st_nxt;
  ldor_pkg::ldor_sel_e   wrSel;
  ldor_pkg::ldor_sel_e   rdSel;
  logic                  doWrite;
  logic                  ackEdge;
  logic                  readEnd;
  logic                  pulseMode;
  logic [1:0]            intSet;
  logic [1:0]            intClr;
  logic                  flagClr;
  logic [7:0]            rdVal;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------

  // one copy of the whole state, filled in a single pass
  always_comb begin
    st_nxt    = st_r;
    wrSel     = decodeAddr(st_r.awAddr);
    rdSel     = decodeAddr(araddr);
    doWrite   = st_r.awHeld && st_r.wHeld && !st_r.bvalid;
    ackEdge   = ackN && !st_r.ackDly;
    readEnd   = st_r.readDly && !eppStatusRead;
    pulseMode = st_r.ppMode[`LDOR_PP_PULSE_BIT] && isEpp(st_r.ppMode[2:0]);
    intSet    = 2'h0;
    intClr    = 2'h0;
    flagClr   = 1'b0;
    rdVal     = 8'h00;

    // address and data channels are taken in either order
    if (awvalid && st_r.awready) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.wHeld  = 1'b1;
      st_nxt.wData  = wdata[7:0];
      st_nxt.wStrb0 = wstrb[0];
    end

    // register writes; only byte lane 0 carries data
    if (doWrite) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = (wrSel == ldor_pkg::SEL_NONE) ? `LDOR_RESP_SLVERR : `LDOR_RESP_OKAY;
      if (st_r.wStrb0) begin
        if (wrSel == ldor_pkg::SEL_PP_MODE) begin
          st_nxt.ppMode = st_r.wData;
        end else if (wrSel == ldor_pkg::SEL_PP_MODE2) begin
          st_nxt.ppMode2 = st_r.wData & `LDOR_PP2_WMASK;
        end else if (wrSel == ldor_pkg::SEL_SER1) begin
          st_nxt.serMode = st_r.wData & `LDOR_SER1_WMASK;
        end else if (wrSel == ldor_pkg::SEL_DTYPE) begin
          st_nxt.driveType = st_r.wData;
        end else if (wrSel == ldor_pkg::SEL_DRV0) begin
          st_nxt.drv0 = st_r.wData & `LDOR_DRV_WMASK;
        end else if (wrSel == ldor_pkg::SEL_DRV1) begin
          st_nxt.drv1 = st_r.wData & `LDOR_DRV_WMASK;
        end else if (wrSel == ldor_pkg::SEL_INT_STAT) begin
          intClr = st_r.wData[1:0];
        end else if (wrSel == ldor_pkg::SEL_INT_MASK) begin
          st_nxt.intMask = st_r.wData[1:0];
        end else if (wrSel == ldor_pkg::SEL_EPP_FLAG) begin
          // write-one clear only when the read-clear method is off
          flagClr = st_r.wData[0] && !st_r.ppMode2[`LDOR_PP2_TMO_BIT];
        end
      end
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = !st_nxt.awHeld && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.wHeld && !st_nxt.bvalid;

    // read mux; F3 and unmapped space read as zero
    if (rdSel == ldor_pkg::SEL_PP_MODE) begin
      rdVal = st_r.ppMode;
    end else if (rdSel == ldor_pkg::SEL_PP_MODE2) begin
      rdVal = st_r.ppMode2;
    end else if (rdSel == ldor_pkg::SEL_SER1) begin
      rdVal = st_r.serMode;
    end else if (rdSel == ldor_pkg::SEL_DTYPE) begin
      rdVal = st_r.driveType;
    end else if (rdSel == ldor_pkg::SEL_FRSVD) begin
      rdVal = 8'h00;
    end else if (rdSel == ldor_pkg::SEL_DRV0) begin
      rdVal = st_r.drv0;
    end else if (rdSel == ldor_pkg::SEL_DRV1) begin
      rdVal = st_r.drv1;
    end else if (rdSel == ldor_pkg::SEL_INT_STAT) begin
      rdVal = {6'h00, st_r.intStat};
    end else if (rdSel == ldor_pkg::SEL_INT_MASK) begin
      rdVal = {6'h00, st_r.intMask};
    end else if (rdSel == ldor_pkg::SEL_EPP_FLAG) begin
      rdVal = {7'h00, st_r.eppFlag};
    end
    if (arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rdVal;
      st_nxt.rresp  = (rdSel == ldor_pkg::SEL_NONE) ? `LDOR_RESP_SLVERR : `LDOR_RESP_OKAY;
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // timeout flag: read-end clear is only armed in method one; set wins
    st_nxt.readDly = eppStatusRead;
    if (readEnd && st_r.ppMode2[`LDOR_PP2_TMO_BIT]) begin
      flagClr = 1'b1;
    end
    st_nxt.eppFlag = (st_r.eppFlag && !flagClr) || eppTimeoutSet;

    // parallel interrupt pin; style bit only matters in epp modes
    st_nxt.ackDly = ackN;
    if (isEcp(st_r.ppMode[2:0])) begin
      st_nxt.ppIrqOe  = 1'b1;
      st_nxt.ppIrqOut = ecpIrqReq;
    end else if (pulseMode) begin
      // one low cycle per acknowledge, then let the pin float
      st_nxt.ppIrqOe  = ackEdge;
      st_nxt.ppIrqOut = 1'b0;
    end else begin
      st_nxt.ppIrqOe  = 1'b1;
      st_nxt.ppIrqOut = ackN;
    end

    // sharing ties both lines to either request
    if (st_r.serMode[`LDOR_SER_SHARE]) begin
      st_nxt.uart1Out = uart1Irq || uart2Irq;
      st_nxt.uart2Out = uart1Irq || uart2Irq;
    end else begin
      st_nxt.uart1Out = uart1Irq;
      st_nxt.uart2Out = uart2Irq;
    end

    // sticky status; a set in the clearing cycle survives
    intSet[`LDOR_INT_TMO] = eppTimeoutSet;
    intSet[`LDOR_INT_ACK] = ackEdge;
    st_nxt.intStat = (st_r.intStat & ~intClr) | intSet;
    st_nxt.irq     = |(st_nxt.intStat & st_nxt.intMask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // reset loads defaults for every power and bus reset case alike
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r           <= '0;
      st_r.ppMode    <= `LDOR_PP_MODE_RST;
      st_r.ppMode2   <= `LDOR_PP_MODE2_RST;
      st_r.serMode   <= `LDOR_SER1_RST;
      st_r.driveType <= `LDOR_DTYPE_RST;
      st_r.drv0      <= `LDOR_DRV_RST;
      st_r.drv1      <= `LDOR_DRV_RST;
      st_r.awready   <= 1'b1;
      st_r.wready    <= 1'b1;
      st_r.arready   <= 1'b1;
      st_r.ackDly    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all taken from the state register
  // ----------------------------------------------------------------

  assign awready         = st_r.awready;
  assign wready          = st_r.wready;
  assign bvalid          = st_r.bvalid;
  assign bresp           = st_r.bresp;
  assign arready         = st_r.arready;
  assign rvalid          = st_r.rvalid;
  assign rresp           = st_r.rresp;
  assign rdata           = {24'h000000, st_r.rdata};
  assign irq             = st_r.irq;
  assign driveTypeStore  = st_r.driveType;
  assign drive0Opt       = '{st_r.drv0[1:0], st_r.drv0[4:3], st_r.drv0[`LDOR_PRECOMP_BIT]};
  assign drive1Opt       = '{st_r.drv1[1:0], st_r.drv1[4:3], st_r.drv1[`LDOR_PRECOMP_BIT]};
  assign parallelOpt     = '{ldor_pkg::ldor_ppmode_e'(st_r.ppMode[2:0]), st_r.ppMode[6:3],
                             st_r.ppMode[`LDOR_PP_PULSE_BIT], st_r.ppMode2[`LDOR_PP2_TMO_BIT]};
  assign serialOpt       = '{st_r.serMode[0], st_r.serMode[1], st_r.serMode[`LDOR_SER_SHARE]};
  assign ppIrqOut        = st_r.ppIrqOut;
  assign ppIrqOe         = st_r.ppIrqOe;
  assign eppTimeoutFlag  = st_r.eppFlag;
  assign uart1IrqOut     = st_r.uart1Out;
  assign uart2IrqOut     = st_r.uart2Out;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seqAckPulse;
    pulseMode && !isEcp(st_r.ppMode[2:0]) && ackEdge;
  endsequence

  sequence seqLowThenFloat;
    (ppIrqOe && !ppIrqOut) ##1 (!ppIrqOe || !pulseMode);
  endsequence

  chk_reset_defaults: assert property ($past(rst) |-> st_r.driveType == 8'hff && st_r.drv0 == 8'h00 && st_r.drv1 == 8'h00 && st_r.ppMode == 8'h3c && st_r.serMode == 8'h00) else $error("register defaults wrong after reset");
  chk_frsvd_zero: assert property ((arvalid && arready && decodeAddr(araddr) == ldor_pkg::SEL_FRSVD) |=> rvalid && rdata == 32'h0) else $error("reserved floppy index read nonzero");
  chk_drv_ro_zero: assert property ((st_r.drv0 & 8'ha4) == 8'h00 && (st_r.drv1 & 8'ha4) == 8'h00) else $error("read-only drive option bits set");
  chk_ack_pulse: assert property (seqAckPulse |=> seqLowThenFloat) else $error("pulsed interrupt shape wrong");
  chk_ecp_level: assert property (isEcp(st_r.ppMode[2:0]) |=> ppIrqOe && ppIrqOut == $past(ecpIrqReq)) else $error("ecp interrupt not level");
  chk_spp_follow: assert property ((st_r.ppMode[1:0] == 2'b00) |=> ppIrqOe && ppIrqOut == $past(ackN)) else $error("printer or spp interrupt not following ack");
  chk_tmo_readclr: assert property ((st_r.eppFlag && readEnd && st_r.ppMode2[4] && !eppTimeoutSet) |=> !eppTimeoutFlag) else $error("timeout flag not cleared after read");
  chk_tmo_hold: assert property ((st_r.eppFlag && !st_r.ppMode2[4] && !doWrite) |=> eppTimeoutFlag) else $error("timeout flag lost without write");
  chk_share_irq: assert property ((st_r.serMode[7] && (uart1Irq || uart2Irq)) |=> uart1IrqOut && uart2IrqOut) else $error("shared interrupt not on both lines");
  chk_own_irq: assert property (!st_r.serMode[7] |=> uart2IrqOut == $past(uart2Irq)) else $error("unshared serial line wrong");
  chk_write_resp: assert property ((awvalid && awready && wvalid && wready) |=> ##[1:2] bvalid) else $error("write response missing");

endmodule

// ---- sim/logical_device_option_registers_tb.sv ----
`timescale 1ns/1ps
`include "ldor_defines.svh"

module logical_device_option_registers_tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clock, awready, wready, bvalid, arready, rvalid, irq, ppIrqOut, ppIrqOe;
  logic        eppTimeoutFlag, uart1IrqOut, uart2IrqOut;
  logic        rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ackN = 1'b1, ecpIrqReq = 1'b0, eppTimeoutSet = 1'b0, eppStatusRead = 1'b0;
  logic        uart1Irq = 1'b0, uart2Irq = 1'b0;
  logic [12:0] awaddr = 13'h0, araddr = 13'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic [7:0]  driveTypeStore;
  ldor_pkg::ldor_drvopt_s drive0Opt, drive1Opt;
  ldor_pkg::ldor_paropt_s parallelOpt;
  ldor_pkg::ldor_seropt_s serialOpt;
  int          miscompares = 0, checked = 0, k;
  // register map: floppy f2..f5, parallel f0 f1, serial f0
  localparam logic [12:0] RA [7] = '{13'h3c8, 13'h3cc, 13'h3d0, 13'h3d4, 13'hfc0, 13'hfc4, 13'h13c0};
  localparam logic [7:0]  RV [7] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h00, 8'h00};
  localparam logic [7:0]  WV [7] = '{8'h5a, 8'hff, 8'hff, 8'hff, 8'h3a, 8'hff, 8'hff};
  localparam logic [7:0]  EV [7] = '{8'h5a, 8'h00, 8'h5b, 8'h5b, 8'h3a, 8'h10, 8'h83};
  localparam logic [12:0] STAT = 13'h1c00, MASK = 13'h1c04, FLAG = 13'h1c08;

  ldor_option_regs dut (.clock, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq,
    .driveTypeStore, .drive0Opt, .drive1Opt, .parallelOpt, .serialOpt, .ackN, .ecpIrqReq, .ppIrqOut,
    .ppIrqOe, .eppTimeoutSet, .eppStatusRead, .eppTimeoutFlag, .uart1Irq, .uart2Irq, .uart1IrqOut,
    .uart2IrqOut);

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // bounded waits end the run rather than hang it
  task lost;
    miscompares++;
    $display("MISMATCH at %0t: bus answer missing", $time);
    summarize();
  endtask

  // each channel drops its valid only at the edge it is taken
  task wr(input logic [12:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 100) lost();
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
    @(posedge clock);
  endtask

  task rd(input logic [12:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 100) lost();
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
    @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(10);
    rst <= 1'b0;
    tick(1);
    for (int i = 0; i < 7; i++) rd(RA[i], 32'(RV[i]), 2'h0);
    // read-only bits must survive a write of ones; F2 and parallel f0 take 5a and 3a instead
    for (int i = 0; i < 7; i++) begin
      wr(RA[i], WV[i], 2'h0);
      rd(RA[i], 32'(EV[i]), 2'h0);
    end
    chk(32'(driveTypeStore), 32'h5a);
    chk(32'(drive1Opt), 32'h1f);
    chk(32'(serialOpt), 32'h7);
    chk(32'(parallelOpt), 32'h09d);
    wr(RA[2], 8'h40, 2'h0);
    chk(32'(drive0Opt), 32'h1);
    wr(13'h1ffc, 8'h11, 2'h2);
    rd(13'h1ffc, 32'h0, 2'h2);
    // every mode with level style; ecp modes follow the core request
    for (int m = 0; m < 8; m++) begin
      wr(RA[4], {5'b00111, 3'(m)}, 2'h0);
      chk(32'(parallelOpt.mode), 32'(m));
      ackN <= 1'b0;
      ecpIrqReq <= 1'b1;
      tick(3);
      chk(32'({ppIrqOe, ppIrqOut}), 32'({1'b1, m == 2 || m == 3 || m == 7}));
      ackN <= 1'b1;
      ecpIrqReq <= 1'b0;
      tick(3);
    end
    // pulse style in epp: released until the ack edge, then one low cycle
    wr(RA[4], 8'hb9, 2'h0);
    ackN <= 1'b0;
    tick(3);
    chk(32'(ppIrqOe), 32'h0);
    ackN <= 1'b1;
    k = 0;
    repeat (6) begin
      @(posedge clock);
      if (ppIrqOe === 1'b1) k = k + ((ppIrqOut === 1'b0) ? 1 : 10);
    end
    chk(32'(k), 32'h1);
    wr(RA[4], 8'hbc, 2'h0);
    ackN <= 1'b0;
    tick(3);
    chk(32'({ppIrqOe, ppIrqOut}), 32'h2);
    ackN <= 1'b1;
    tick(2);
    // status, mask and the two timeout clear methods
    wr(STAT, 8'h03, 2'h0);
    wr(MASK, 8'h01, 2'h0);
    chk(32'(irq), 32'h0);
    eppTimeoutSet <= 1'b1;
    @(posedge clock);
    eppTimeoutSet <= 1'b0;
    tick(3);
    chk(32'({irq, eppTimeoutFlag}), 32'h3);
    rd(STAT, 32'h1, 2'h0);
    wr(STAT, 8'h01, 2'h0);
    tick(2);
    chk(32'(irq), 32'h0);
    wr(FLAG, 8'h01, 2'h0);
    tick(2);
    chk(32'(eppTimeoutFlag), 32'h1);
    eppStatusRead <= 1'b1;
    tick(2);
    eppStatusRead <= 1'b0;
    tick(3);
    chk(32'(eppTimeoutFlag), 32'h0);
    wr(RA[5], 8'h00, 2'h0);
    eppTimeoutSet <= 1'b1;
    @(posedge clock);
    eppTimeoutSet <= 1'b0;
    tick(3);
    chk(32'({irq, eppTimeoutFlag}), 32'h3);
    wr(FLAG, 8'h01, 2'h0);
    tick(2);
    chk(32'(eppTimeoutFlag), 32'h0);
    wr(MASK, 8'h00, 2'h0);
    tick(2);
    chk(32'(irq), 32'h0);
    // serial lines separate, then shared
    wr(RA[6], 8'h00, 2'h0);
    uart1Irq <= 1'b1;
    tick(3);
    chk(32'({uart1IrqOut, uart2IrqOut}), 32'h2);
    wr(RA[6], 8'h80, 2'h0);
    tick(2);
    chk(32'({uart1IrqOut, uart2IrqOut}), 32'h3);
    uart1Irq <= 1'b0;
    uart2Irq <= 1'b1;
    tick(3);
    chk(32'({uart1IrqOut, uart2IrqOut}), 32'h3);
    // second reset in mid-run restores defaults
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    rd(RA[4], 32'h3c, 2'h0);
    rd(RA[6], 32'h0, 2'h0);
    summarize();
  end
endmodule
